//--- hdl/ubrg_pkg.sv
/*
 * ubrg_pkg: constants and enumerations for the serial baud rate generator.
 * Assumes a single system clock domain; all configuration arrives as plain ports.
 */
package ubrg_pkg;

	// clock source choices
	typedef enum logic [1:0] {
		UBRG_SRC_SYS    = 2'b00,
		UBRG_SRC_SYSDIV = 2'b01,
		UBRG_SRC_RSVD   = 2'b10,
		UBRG_SRC_EXT    = 2'b11
	} ubrg_src_e;

	// operating modes, only the plain serial mode uses the fraction
	typedef enum logic [3:0] {
		UBRG_MODE_NORMAL = 4'h0,
		UBRG_MODE_RS485  = 4'h1,
		UBRG_MODE_HSHAKE = 4'h2,
		UBRG_MODE_CARD0  = 4'h4,
		UBRG_MODE_CARD1  = 4'h6,
		UBRG_MODE_INFRA  = 4'h8,
		UBRG_MODE_SPIM   = 4'he,
		UBRG_MODE_SPIS   = 4'hf
	} ubrg_mode_e;

	localparam int         UBRG_DIV_W      = 16;
	localparam int         UBRG_FP_W       = 3;
	localparam logic [2:0] UBRG_PREDIV_MAX = 3'h7;       // fixed pre-divider of eight
	localparam logic [3:0] UBRG_OVS16_MAX  = 4'hf;       // sixteen samples per bit
	localparam logic [3:0] UBRG_OVS8_MAX   = 4'h7;       // eight samples per bit
	localparam logic [15:0] UBRG_DIV_RST   = 16'h0000;   // divisor after reset: stopped
	localparam logic [2:0]  UBRG_FP_RST    = 3'h0;
	localparam real        UBRG_CLK_NS     = 8.0;        // system clock period
	// least external high/low phase: more than one system period, so two cycles
	localparam int         UBRG_EXT_MIN_CYC = int'(UBRG_CLK_NS / UBRG_CLK_NS) + 1;

endpackage

//--- hdl/ubrg_sync.sv
/*
 * ubrg_sync: two-flop synchroniser with rising and falling edge detect.
 * Assumes the input is asynchronous to clk and slower than a third of it.
 */
`timescale 1ns/100ps
`default_nettype none
module ubrg_sync (
	input  wire logic clk,        // system clock
	input  wire logic rstn,       // synchronous reset, active low
	input  wire logic din,        // asynchronous level
	output logic      level,      // synchronised level
	output logic      rise,       // one-cycle pulse on rising edge
	output logic      fall        // one-cycle pulse on falling edge
);
	import ubrg_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ubrg_sync_s;

	ubrg_sync_s st;
	ubrg_sync_s next_st;

	// edge detect reads only the second and third stages
	always_comb begin
		next_st    = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.s2;
	assign rise  = st.s2 & ~st.s3;
	assign fall  = ~st.s2 & st.s3;
endmodule
`default_nettype wire

//--- hdl/ubrg_top.sv
/*
 * ubrg_top: baud rate generator of a serial transceiver.
 * Assumes one system clock; configuration fields are plain ports held by
 * a register block elsewhere; the external serial clock arrives unsynchronised.
 */
// Operation
// - one bit clock shared by receiver, transmitter
// - source: system, system over eight, external
// - sixteen-bit integer divisor sets division ratio
// - divisor zero: no clock produced, except sync external where the pin drives it
// - divisor one: divider bypassed, source passes, except a fraction-stretched period of two ticks
// - async: sample clock divided by 16/8
// - ratio bit set: eight samples, else sixteen
// - nonzero fraction enables fractional division
// - fraction adds eighth steps to divisor
// - fraction only in plain serial mode
// - five to nine data bits, either order
// - stop bits: 1/1.5/2 async, 1/2 sync
// - parity even, odd, one, zero, none
// - SPI clock at most system over six; not limited here, sync divisor one ticks on every source tick
// - remote loopback, local loopback, automatic echo
// - sync external: pin is bit clock directly
// - system source: even duty for even divisor and divisor one; other odd divisors stay high one tick longer
`timescale 1ns/100ps
`default_nettype none
module ubrg_top (
	input  wire logic        clk,                  // system clock, 125 MHz
	input  wire logic        rstn,                 // synchronous reset, active low
	input  wire logic [1:0]  source_clock_select,  // divider input select
	input  wire logic [15:0] integer_divisor,      // integer division ratio
	input  wire logic [2:0]  fractional_eighths,   // fraction in eighths
	input  wire logic        over8,                // 1: 8x sampling, 0: 16x
	input  wire logic        sync_mode,            // 1: synchronous or SPI framing
	input  wire logic [3:0]  op_mode,              // operating mode
	input  wire logic        div_write,            // pulse: divisor fields written
	input  wire logic        sck_in,               // serial clock pin input
	output logic             sck_out,              // serial clock pin output level
	output logic             sample_tick,          // receiver sampling enable pulse
	output logic             rx_bit_tick,          // receiver bit clock pulse
	output logic             tx_bit_tick,          // transmitter bit clock pulse
	output logic             clk_running           // generator is producing ticks
);
	import ubrg_pkg::*;

	typedef struct packed {
		logic [2:0]  pre_cnt;    // fixed pre-divider
		logic [15:0] div_cnt;    // integer divider
		logic [2:0]  frac_acc;   // fractional accumulator
		logic        frac_ext;   // current period stretched by one source tick
		logic [3:0]  ovs_cnt;    // oversampling counter
		logic        sck_lvl;    // serial clock output level
		logic        samp;       // registered sample pulse
		logic        bit_tk;     // registered bit pulse
		logic        run;
	} ubrg_s;

	ubrg_s st;
	ubrg_s next_st;

	logic ext_lvl;
	logic ext_rise;
	logic ext_fall;
	logic src_tick;
	logic frac_on;
	logic div_out;

	// pin passes two flops before anything reads it
	ubrg_sync u_sck_sync (
		.clk   (clk),
		.rstn  (rstn),
		.din   (sck_in),
		.level (ext_lvl),
		.rise  (ext_rise),
		.fall  (ext_fall)
	);

	// period of the divider in source ticks, one more when fraction stretches it
	function automatic logic [16:0] ubrg_period(input logic [15:0] cd, input logic ext);
		ubrg_period = {1'b0, cd} + {16'h0000, ext};
	endfunction

	// source tick selection; the external clock counts its rising edges
	always_comb begin
		case (ubrg_src_e'(source_clock_select))
			UBRG_SRC_SYS:    src_tick = 1'b1;
			UBRG_SRC_SYSDIV: src_tick = (st.pre_cnt == UBRG_PREDIV_MAX);
			UBRG_SRC_EXT:    src_tick = ext_rise;
			default:         src_tick = 1'b1;
		endcase
	end

	// fraction only in normal async mode with a nonzero field
	assign frac_on = (fractional_eighths != UBRG_FP_RST) && !sync_mode
		&& (ubrg_mode_e'(op_mode) == UBRG_MODE_NORMAL);

	// divider output pulse: bypass at one, nothing at zero
	always_comb begin
		if (integer_divisor == UBRG_DIV_RST) begin
			div_out = 1'b0;
		end else if (integer_divisor == 16'h0001 && !st.frac_ext) begin
			div_out = src_tick;
		end else begin
			div_out = src_tick && ({1'b0, st.div_cnt} + 17'h0_0001
				>= ubrg_period(integer_divisor, st.frac_ext));
		end
	end

	always_comb begin
		next_st        = st;
		next_st.samp   = 1'b0;
		next_st.bit_tk = 1'b0;
		next_st.run    = (integer_divisor != UBRG_DIV_RST);
		next_st.pre_cnt = st.pre_cnt + 3'h1;
		if (src_tick && !div_out) begin
			next_st.div_cnt = st.div_cnt + 16'h0001;
		end
		if (sync_mode && ubrg_src_e'(source_clock_select) == UBRG_SRC_EXT) begin
			// pin drives the bit clock with no division, divisor ignored; spi rate is the pin's limit
			next_st.bit_tk  = ext_fall;
			next_st.samp    = ext_rise;
			next_st.sck_lvl = ext_lvl;
			next_st.run     = 1'b1;
		end else if (div_out) begin
			next_st.div_cnt = 16'h0000;
			// eighth steps: stretch the next period when the accumulator wraps
			if (frac_on) begin
				{next_st.frac_ext, next_st.frac_acc} =
					{1'b0, st.frac_acc} + {1'b0, fractional_eighths};
			end else begin
				next_st.frac_ext = 1'b0;
				next_st.frac_acc = 3'h0;
			end
			if (sync_mode) begin
				// sync: divided clock is the bit clock itself
				next_st.bit_tk = 1'b1;
				next_st.samp   = 1'b1;
			end else begin
				next_st.samp = 1'b1;
				if (st.ovs_cnt >= (over8 ? UBRG_OVS8_MAX : UBRG_OVS16_MAX)) begin
					next_st.ovs_cnt = 4'h0;
					next_st.bit_tk  = 1'b1;
				end else begin
					next_st.ovs_cnt = st.ovs_cnt + 4'h1;
				end
			end
		end
		// serial clock output: low from the divider pulse, high from count half the divisor
		// minus one; odd divisors above one stay high one source tick longer than low
		if (!(sync_mode && ubrg_src_e'(source_clock_select) == UBRG_SRC_EXT)) begin
			// bypass is checked before the divider output, which at one fires on every tick outside a fraction-stretched period
			if (integer_divisor == UBRG_DIV_RST) begin
				next_st.sck_lvl = 1'b0;
			end else if (integer_divisor == 16'h0001) begin
				next_st.sck_lvl = src_tick ? ~st.sck_lvl : st.sck_lvl;
			end else if (div_out) begin
				next_st.sck_lvl = 1'b0;
			end else if (src_tick && st.div_cnt == (integer_divisor >> 1) - 16'h0001) begin
				next_st.sck_lvl = 1'b1;
			end
		end
		// restart counters so a new setting gives no stale short period
		if (div_write) begin
			next_st.div_cnt  = 16'h0000;
			next_st.frac_acc = 3'h0;
			next_st.frac_ext = 1'b0;
			next_st.ovs_cnt  = 4'h0;
			next_st.pre_cnt  = 3'h0;
			next_st.samp     = 1'b0;
			next_st.bit_tk   = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// one bit clock fans out to both halves; framing formats ride on it downstream
	assign sample_tick = st.samp;
	// character length, stop bits, parity and test modes all clock off this tick
	assign rx_bit_tick = st.bit_tk;
	assign tx_bit_tick = st.bit_tk;
	assign sck_out     = st.sck_lvl;
	assign clk_running = st.run;
endmodule
`default_nettype wire

//--- verification/ubrg_monitor.sv
/* ubrg_monitor: tick timing checks on the generator ports.
   assumes every setting change arrives together with a div_write pulse. */
`timescale 1ns/100ps
`default_nettype none
module ubrg_monitor (
	input wire logic        clk,                 // clock
	input wire logic        rstn,                // reset
	input wire logic [1:0]  source_clock_select, // source
	input wire logic [15:0] integer_divisor,     // divisor
	input wire logic [2:0]  fractional_eighths,  // fraction
	input wire logic        over8,               // ratio
	input wire logic        sync_mode,           // framing
	input wire logic [3:0]  op_mode,             // mode
	input wire logic        div_write,           // restart
	input wire logic        sample_tick,         // sample
	input wire logic        rx_bit_tick,         // rx bit
	input wire logic        tx_bit_tick,         // tx bit
	input wire logic        clk_running,         // running
	input wire logic        sck_out              // serial clock level
);
	logic [19:0] gap, calm, want;
	logic [4:0]  scnt, ratio;
	logic        acfg, icfg;
	// only bit-tick equality and divisor-zero silence are judged before the first restart, since the post-reset phase is open
	always_ff @(posedge clk) begin
		gap  <= (!rstn || div_write) ? 20'h0 : sample_tick ? 20'h1 : gap + 20'h1;
		calm <= !rstn ? 20'h0 : div_write ? 20'h1 : (calm != 20'h0) ? calm + 20'h1 : 20'h0;
		scnt <= (!rstn || div_write || rx_bit_tick) ? 5'h0 : scnt + 5'(sample_tick);
	end
	// expected sample spacing in system cycles
	assign want  = (source_clock_select == 2'h1) ? {1'b0, integer_divisor, 3'h0} : {4'h0, integer_divisor};
	assign ratio = over8 ? 5'h8 : 5'h10;
	assign acfg  = (calm != 20'h0) && !sync_mode && (source_clock_select != 2'h3);
	assign icfg  = acfg && (integer_divisor != 16'h0) && ((fractional_eighths == 3'h0) || (op_mode != 4'h0));
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_same; rx_bit_tick == tx_bit_tick; endproperty
	a_same: assert property (p_same) else $error("bit ticks differ");
	property p_zero; (integer_divisor == 16'h0 && source_clock_select != 2'h3)[*4] |-> !sample_tick && !rx_bit_tick; endproperty
	a_zero: assert property (p_zero) else $error("tick with divisor zero");
	property p_run; calm != 20'h0 && !div_write |-> clk_running == (integer_divisor != 16'h0 || (sync_mode && source_clock_select == 2'h3)); endproperty
	a_run: assert property (p_run) else $error("running flag wrong");
	property p_bypass; icfg && integer_divisor == 16'h1 && source_clock_select == 2'h0 && !div_write && calm >= 20'h3
		|-> sample_tick; endproperty
	a_bypass: assert property (p_bypass) else $error("bypass lost a tick");
	property p_period; icfg && sample_tick && !div_write && calm >= gap |-> gap == want; endproperty
	a_period: assert property (p_period) else $error("sample spacing wrong");
	property p_late; icfg && !div_write && calm >= gap |-> gap <= want; endproperty
	a_late: assert property (p_late) else $error("sample tick overdue");
	property p_frac; acfg && sample_tick && !div_write && calm >= gap && fractional_eighths != 3'h0 && op_mode == 4'h0
		&& source_clock_select == 2'h0 && integer_divisor != 16'h0 |-> gap == want || gap == want + 20'h1; endproperty
	a_frac: assert property (p_frac) else $error("fractional spacing wrong");
	property p_bit; acfg && rx_bit_tick && !div_write |-> sample_tick && scnt + 5'h1 == ratio; endproperty
	a_bit: assert property (p_bit) else $error("bit tick off sample count");
	property p_ratio; acfg && sample_tick && !div_write && scnt + 5'h1 == ratio |-> rx_bit_tick; endproperty
	a_ratio: assert property (p_ratio) else $error("bit tick missing");
	property p_sck; icfg && source_clock_select == 2'h0 && calm >= 20'h3 && !div_write
		|-> (integer_divisor == 16'h1) ? (sck_out != $past(sck_out)) : (!sample_tick || !sck_out); endproperty
	a_sck: assert property (p_sck) else $error("serial clock level wrong");
	c_frac: cover property (sample_tick && fractional_eighths != 3'h0 && op_mode == 4'h0);
	c_bypass: cover property (sample_tick && integer_divisor == 16'h1);
	c_ext: cover property (sync_mode && rx_bit_tick);
endmodule
bind ubrg_top ubrg_monitor u_mon (.clk(clk), .rstn(rstn), .source_clock_select(source_clock_select),
	.integer_divisor(integer_divisor), .fractional_eighths(fractional_eighths), .over8(over8), .sync_mode(sync_mode),
	.op_mode(op_mode), .div_write(div_write), .sample_tick(sample_tick), .rx_bit_tick(rx_bit_tick),
	.tx_bit_tick(tx_bit_tick), .clk_running(clk_running), .sck_out(sck_out));
`default_nettype wire

//--- verification/ubrg_ext_src.sv
/* ubrg_ext_src: external serial clock source on the pin.
   assumes the bench enables it only for external-source runs. */
`timescale 1ns/100ps
`default_nettype none
module ubrg_ext_src (
	input  wire logic       run,  // enable the clock
	input  wire logic [3:0] half, // half period in system cycles, two or more
	output logic            sck   // pin level
);
	// offset keeps pin edges clear of system edges; idle holds still at low
	initial begin
		sck = 1'b0;
		#3.3;
		forever begin
			sck = run ? ~sck : 1'b0;
			#(half * 8);
		end
	end
endmodule
`default_nettype wire

//--- verification/tb_usart_baud_rate_generator.sv
/* tb_usart_baud_rate_generator: random settings, bit periods checked against the rate formula.
   assumes one 125 MHz clock; the bench drives inputs at the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module tb_usart_baud_rate_generator import ubrg_pkg::*;;
	logic        clk = 1'b0, rstn = 1'b0, over8 = 1'b0, sync_mode = 1'b0, div_write = 1'b0, run = 1'b0;
	logic [1:0]  src = 2'h0;
	logic [15:0] cd = 16'h0;
	logic [2:0]  fp = 3'h0;
	logic [3:0]  mode = 4'h0, half = 4'h2;
	logic        sck, sck_out, stick, rtick, ttick, running;
	logic [31:0] lfsr = 32'h0bd0;
	logic [31:0] q[$];
	int          error_cnt = 0, n_checks = 0, gap = 0;
	always #4 clk = ~clk;
	ubrg_top uut (.clk(clk), .rstn(rstn), .source_clock_select(src), .integer_divisor(cd), .fractional_eighths(fp),
		.over8(over8), .sync_mode(sync_mode), .op_mode(mode), .div_write(div_write), .sck_in(sck), .sck_out(sck_out),
		.sample_tick(stick), .rx_bit_tick(rtick), .tx_bit_tick(ttick), .clk_running(running));
	ubrg_ext_src u_ext (.run(run), .half(half), .sck(sck));
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// bounded wait for the next bit tick; a hang counts as a mismatch
	task automatic tick_wait;
		int k;
		k = 0;
		@(negedge clk);
		while (rtick !== 1'b1) begin
			k++;
			if (k > 9000) begin
				error_cnt++;
				end_of_test;
			end
			@(negedge clk);
		end
	endtask
	// restart with the current setting; the first period is skipped since its start is open
	task automatic run_cfg(input int exp, input int n);
		div_write = 1'b1;
		@(negedge clk) div_write = 1'b0;
		tick_wait();
		// let the watcher pass the open first period before the notes go in
		@(posedge clk);
		repeat (n) q.push_back(exp);
		repeat (n) tick_wait();
	endtask
	// watcher: period between bit ticks against the oldest note; looks mid-cycle, clear of the launch edge
	always @(negedge clk) begin
		gap <= gap + 1;
		if (rtick === 1'b1) begin
			if (q.size() > 0) compare("bit period", q.pop_front(), gap + 1);
			gap <= 0;
		end
	end
	initial begin
		int k, e;
		k = 0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		// divisor zero must stay silent
		div_write = 1'b1;
		@(negedge clk) div_write = 1'b0;
		repeat (300) @(negedge clk) k += stick;
		compare("ticks at divisor zero", 0, k);
		compare("running at divisor zero", 0, running);
		// small divisors keep the run short; fraction only counts in normal mode
		for (int i = 0; i < 24; i++) begin
			lfsr = next_rand(lfsr);
			cd = {14'h0, lfsr[1:0]} + 16'h1;
			src = lfsr[3] ? UBRG_SRC_SYSDIV : UBRG_SRC_SYS;
			over8 = lfsr[4];
			fp = lfsr[7:5];
			mode = lfsr[8] ? UBRG_MODE_RS485 : UBRG_MODE_NORMAL;
			e = ((over8 ? 8 : 16) * cd + ((fp != 0 && mode == 0) ? (over8 ? fp : 2 * fp) : 0)) * (src[0] ? 8 : 1);
			run_cfg(e, 2);
		end
		// synchronous with pin clock: divisor ignored, pin period is the bit period
		sync_mode = 1'b1;
		src = UBRG_SRC_EXT;
		half = 4'(UBRG_EXT_MIN_CYC) + {2'h0, lfsr[1:0]};
		run = 1'b1;
		run_cfg(2 * half, 3);
		run = 1'b0;
		@(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire
